// ===== design/agu_consts.svh
/*
 * constants for the circular and bit-reversed address generator
 * assumes inclusion by bare name from the design files
 */
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH

`define OFF_X_BUF_START     8'h00
`define OFF_X_BUF_END       8'h04
`define OFF_Y_BUF_START     8'h08
`define OFF_Y_BUF_END       8'h0C
`define OFF_ADDR_MODE_CTRL  8'h10
`define OFF_REV_CTRL        8'h14
`define OFF_STATUS          8'h18
`define RST_BUF_START       16'h0000
`define RST_BUF_END         16'h0000
`define RST_ADDR_MODE_CTRL  16'h0FFF
`define RST_REV_CTRL        16'h0000
`define PTR_SEL_OFF         4'hF
`define X_SEL_LSB           0
`define Y_SEL_LSB           4
`define REV_SEL_LSB         8
`define X_CIRC_EN_BIT       15
`define Y_CIRC_EN_BIT       14
`define REV_EN_BIT          15
`define MAX_CIRC_BYTES      17'h10000
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// ===== design/agu_pkg.sv
/*
 * types for the address generator
 * assumes nothing of its surroundings
 */
package agu_pkg;
	typedef enum logic [1:0] {
		mode_indirect = 2'b00,
		mode_pre      = 2'b01,
		mode_post     = 2'b10,
		mode_offset   = 2'b11
	} addr_mode_t;
endpackage : agu_pkg

// ===== design/circ_correct.sv
/*
 * circular correction of one effective address
 * assumes start <= end, bounds in bytes, combinational use
 */
`timescale 1ns/100ps
`default_nettype none
module circ_correct (
	// operands
	input  wire logic [15:0] ea,
	input  wire logic [15:0] buf_start,
	input  wire logic [15:0] buf_end,
	input  wire logic        enable,
	input  wire logic        word_only,
	// result
	output logic      [15:0] ea_out,
	output logic             wrapped
);
	// length implied by bounds, never stored
	wire logic [16:0] buf_len = {1'b0, buf_end} - {1'b0, buf_start} + 17'h00002;
	wire logic        above   = ea > buf_end;
	wire logic        below   = ea < buf_start;
	wire logic [15:0] up_fix  = 16'(({1'b0, ea} - buf_len));
	wire logic [15:0] dn_fix  = 16'(({1'b0, ea} + buf_len));
	wire logic [15:0] sel     = !enable ? ea : above ? up_fix : below ? dn_fix : ea;
	assign ea_out  = word_only ? {sel[15:1], 1'b0} : sel;
	assign wrapped = enable && (above || below);
endmodule : circ_correct
`default_nettype wire

// ===== design/circular_and_bit_reversed_agu.sv
/*
 * X/Y address generation with circular and bit-reversed modes plus
 * an AXI4-Lite register slave; assumes decode supplies pointer, mode,
 * offset and access size each cycle, and writes back when asked
 */
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "agu_consts.svh"
module circular_and_bit_reversed_agu
	import agu_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// x read request
	input  wire logic        xr_valid,
	input  wire logic [3:0]  xr_reg,
	input  wire logic [15:0] xr_ptr,
	input  wire logic [15:0] xr_offset,
	input  wire addr_mode_t  xr_mode,
	// x write request
	input  wire logic        xw_valid,
	input  wire logic [3:0]  xw_reg,
	input  wire logic [15:0] xw_ptr,
	input  wire logic [15:0] xw_offset,
	input  wire addr_mode_t  xw_mode,
	input  wire logic        xw_word,
	// y request
	input  wire logic        y_valid,
	input  wire logic [3:0]  y_reg,
	input  wire logic [15:0] y_ptr,
	input  wire logic [15:0] y_offset,
	input  wire addr_mode_t  y_mode,
	// x read result
	output logic [15:0]      xr_ea,
	output logic             xr_wb_en,
	output logic [15:0]      xr_wb_val,
	// x write result
	output logic [15:0]      xw_ea,
	output logic             xw_wb_en,
	output logic [15:0]      xw_wb_val,
	output logic             xw_rev_used,
	// y result
	output logic [15:0]      y_ea,
	output logic             y_wb_en,
	output logic [15:0]      y_wb_val
);
	// register file
	logic [15:0] x_buf_start_reg;
	logic [15:0] x_buf_end_reg;
	logic [15:0] y_buf_start_reg;
	logic [15:0] y_buf_end_reg;
	logic [15:0] addr_mode_ctrl_reg;
	logic [15:0] rev_ctrl_reg;
	logic [2:0]  wrap_seen_reg;
	logic [2:0]  wrap_seen_next;

	// bus handshake state
	logic        aw_held_reg;
	logic [7:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;

	// control fields
	wire logic [3:0]  x_mod_ptr_sel = addr_mode_ctrl_reg[`X_SEL_LSB +: 4];
	wire logic [3:0]  y_mod_ptr_sel = addr_mode_ctrl_reg[`Y_SEL_LSB +: 4];
	wire logic [3:0]  rev_ptr_sel   = addr_mode_ctrl_reg[`REV_SEL_LSB +: 4];
	wire logic        x_circ_en     = addr_mode_ctrl_reg[`X_CIRC_EN_BIT];
	wire logic        y_circ_en     = addr_mode_ctrl_reg[`Y_CIRC_EN_BIT];
	wire logic        rev_en        = rev_ctrl_reg[`REV_EN_BIT];
	wire logic [14:0] pivot_value   = rev_ctrl_reg[14:0];
	wire logic        x_circ_on     = x_circ_en && (x_mod_ptr_sel != `PTR_SEL_OFF);
	wire logic        y_circ_on     = y_circ_en && (y_mod_ptr_sel != `PTR_SEL_OFF);

	// raw effective address per mode
	function automatic logic [15:0] raw_ea(input logic [15:0] p, input logic [15:0] o,
		input addr_mode_t m);
		unique case (m)
			mode_indirect: raw_ea = p;
			mode_pre:      raw_ea = p + o;
			mode_post:     raw_ea = p;
			mode_offset:   raw_ea = p + o;
		endcase
	endfunction : raw_ea

	// pointer after the modify step
	function automatic logic [15:0] next_ptr(input logic [15:0] p, input logic [15:0] o,
		input addr_mode_t m);
		next_ptr = (m == mode_pre || m == mode_post) ? p + o : p;
	endfunction : next_ptr

	// x read: circular on the selected register only
	wire logic [15:0] xr_raw   = raw_ea(xr_ptr, xr_offset, xr_mode);
	wire logic [15:0] xr_nxt   = next_ptr(xr_ptr, xr_offset, xr_mode);
	wire logic        xr_circ  = x_circ_on && (xr_reg == x_mod_ptr_sel);
	logic [15:0] xr_ea_c;
	logic [15:0] xr_nxt_c;
	logic        xr_wrap;
	circ_correct xr_cc (.ea(xr_raw), .buf_start(x_buf_start_reg), .buf_end(x_buf_end_reg),
		.enable(xr_circ), .word_only(1'b0), .ea_out(xr_ea_c), .wrapped(xr_wrap));
	circ_correct xr_cn (.ea(xr_nxt), .buf_start(x_buf_start_reg), .buf_end(x_buf_end_reg),
		.enable(xr_circ), .word_only(1'b0), .ea_out(xr_nxt_c), .wrapped());

	// x write: bit reverse wins, circular only when not reversing
	wire logic xw_incr = (xw_mode == mode_pre || xw_mode == mode_post) && !xw_offset[15];
	wire logic xw_rev  = rev_en && (rev_ptr_sel != `PTR_SEL_OFF) && (xw_reg == rev_ptr_sel)
		&& xw_incr && xw_word;
	wire logic [15:0] pivot_bytes = {pivot_value, 1'b0};

	// reversed-carry add: reverse, add, reverse back
	logic [15:0] ptr_rev;
	logic [15:0] piv_rev;
	logic [15:0] sum_rev;
	logic [15:0] rev_sum;
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_rev
			assign ptr_rev[gi] = xw_ptr[15 - gi];
			assign piv_rev[gi] = pivot_bytes[15 - gi];
			assign rev_sum[gi] = sum_rev[15 - gi];
		end
	endgenerate
	assign sum_rev = ptr_rev + piv_rev;

	wire logic [15:0] rev_next = {rev_sum[15:1], 1'b0};
	wire logic [15:0] xw_raw   = raw_ea(xw_ptr, xw_offset, xw_mode);
	wire logic [15:0] xw_nxt   = next_ptr(xw_ptr, xw_offset, xw_mode);
	wire logic        xw_circ  = x_circ_on && (xw_reg == x_mod_ptr_sel) && !xw_rev;
	logic [15:0] xw_ea_c;
	logic [15:0] xw_nxt_c;
	logic        xw_wrap;
	circ_correct xw_cc (.ea(xw_raw), .buf_start(x_buf_start_reg), .buf_end(x_buf_end_reg),
		.enable(xw_circ), .word_only(1'b0), .ea_out(xw_ea_c), .wrapped(xw_wrap));
	circ_correct xw_cn (.ea(xw_nxt), .buf_start(x_buf_start_reg), .buf_end(x_buf_end_reg),
		.enable(xw_circ), .word_only(1'b0), .ea_out(xw_nxt_c), .wrapped());

	// pre-increment uses the reversed sum as address, post uses the pointer
	wire logic [15:0] xw_rev_ea = (xw_mode == mode_pre) ? rev_next : {xw_ptr[15:1], 1'b0};

	// y space: word data, lsb forced clear in circular mode
	wire logic [15:0] y_raw  = raw_ea(y_ptr, y_offset, y_mode);
	wire logic [15:0] y_nxt  = next_ptr(y_ptr, y_offset, y_mode);
	wire logic        y_circ = y_circ_on && (y_reg == y_mod_ptr_sel);
	logic [15:0] y_ea_c;
	logic [15:0] y_nxt_c;
	logic        y_wrap;
	circ_correct y_cc (.ea(y_raw), .buf_start(y_buf_start_reg), .buf_end(y_buf_end_reg),
		.enable(y_circ), .word_only(y_circ), .ea_out(y_ea_c), .wrapped(y_wrap));
	circ_correct y_cn (.ea(y_nxt), .buf_start(y_buf_start_reg), .buf_end(y_buf_end_reg),
		.enable(y_circ), .word_only(y_circ), .ea_out(y_nxt_c), .wrapped());

	// write back only for modify modes; offset mode leaves pointer alone
	wire logic xr_mod = (xr_mode == mode_pre) || (xr_mode == mode_post);
	wire logic xw_mod = (xw_mode == mode_pre) || (xw_mode == mode_post);
	wire logic y_mod  = (y_mode == mode_pre) || (y_mode == mode_post);

	// registered results
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xr_ea       <= 16'h0000;
			xr_wb_en    <= 1'b0;
			xr_wb_val   <= 16'h0000;
			xw_ea       <= 16'h0000;
			xw_wb_en    <= 1'b0;
			xw_wb_val   <= 16'h0000;
			xw_rev_used <= 1'b0;
			y_ea        <= 16'h0000;
			y_wb_en     <= 1'b0;
			y_wb_val    <= 16'h0000;
		end else begin
			xr_ea       <= xr_ea_c;
			xr_wb_en    <= xr_valid && xr_mod;
			xr_wb_val   <= xr_nxt_c;
			xw_ea       <= xw_rev ? xw_rev_ea : xw_ea_c;
			xw_wb_en    <= xw_valid && xw_mod;
			xw_wb_val   <= xw_rev ? rev_next : xw_nxt_c;
			xw_rev_used <= xw_valid && xw_rev;
			y_ea        <= y_ea_c;
			y_wb_en     <= y_valid && y_mod;
			y_wb_val    <= y_nxt_c;
		end
	end

	// sticky wrap flags, set wins over clear
	wire logic [2:0] wrap_now = {y_valid && y_wrap, xw_valid && xw_wrap, xr_valid && xr_wrap};

	// axi4-lite write path
	wire logic do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
	// byte lanes above bit 15 carry nothing and are dropped
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready  = !w_held_reg;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	wire logic wr_hit = (aw_addr_reg == `OFF_X_BUF_START) || (aw_addr_reg == `OFF_X_BUF_END)
		|| (aw_addr_reg == `OFF_Y_BUF_START) || (aw_addr_reg == `OFF_Y_BUF_END)
		|| (aw_addr_reg == `OFF_ADDR_MODE_CTRL) || (aw_addr_reg == `OFF_REV_CTRL)
		|| (aw_addr_reg == `OFF_STATUS);
	wire logic clr_status = do_write && (aw_addr_reg == `OFF_STATUS) && w_strb_reg[0];

	always_comb begin
		wrap_seen_next = wrap_seen_reg;
		if (clr_status)
			wrap_seen_next = wrap_seen_reg & ~w_data_reg[2:0];
		wrap_seen_next = wrap_seen_next | wrap_now;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_held_reg   <= 1'b0;
			w_data_reg   <= 32'h00000000;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			x_buf_start_reg    <= `RST_BUF_START;
			x_buf_end_reg      <= `RST_BUF_END;
			y_buf_start_reg    <= `RST_BUF_START;
			y_buf_end_reg      <= `RST_BUF_END;
			addr_mode_ctrl_reg <= `RST_ADDR_MODE_CTRL;
			rev_ctrl_reg       <= `RST_REV_CTRL;
			wrap_seen_reg      <= 3'h0;
		end else begin
			wrap_seen_reg <= wrap_seen_next;
			if (do_write) begin
				unique case (aw_addr_reg)
					`OFF_X_BUF_START:    x_buf_start_reg <= merge(x_buf_start_reg, w_data_reg,
						w_strb_reg);
					`OFF_X_BUF_END:      x_buf_end_reg <= merge(x_buf_end_reg, w_data_reg,
						w_strb_reg);
					`OFF_Y_BUF_START:    y_buf_start_reg <= merge(y_buf_start_reg, w_data_reg,
						w_strb_reg);
					`OFF_Y_BUF_END:      y_buf_end_reg <= merge(y_buf_end_reg, w_data_reg,
						w_strb_reg);
					`OFF_ADDR_MODE_CTRL: addr_mode_ctrl_reg <= merge(addr_mode_ctrl_reg,
						w_data_reg, w_strb_reg);
					`OFF_REV_CTRL:       rev_ctrl_reg <= merge(rev_ctrl_reg, w_data_reg,
						w_strb_reg);
					default: ;
				endcase
			end
		end
	end

	// axi4-lite read path
	assign s_axi_arready = !s_axi_rvalid;
	wire logic [7:0] ra = {s_axi_araddr[7:2], 2'b00};
	wire logic [15:0] rd_val =
		(ra == `OFF_X_BUF_START)    ? x_buf_start_reg :
		(ra == `OFF_X_BUF_END)      ? x_buf_end_reg :
		(ra == `OFF_Y_BUF_START)    ? y_buf_start_reg :
		(ra == `OFF_Y_BUF_END)      ? y_buf_end_reg :
		(ra == `OFF_ADDR_MODE_CTRL) ? addr_mode_ctrl_reg :
		(ra == `OFF_REV_CTRL)       ? rev_ctrl_reg :
		(ra == `OFF_STATUS)         ? {13'h0000, wrap_seen_reg} : 16'h0000;
	wire logic rd_hit = (ra <= `OFF_STATUS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {16'h0000, rd_val};
			s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks
	y_lsb_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		y_circ |=> !y_ea[0]) else $error("y circular address lsb set");
	x_off_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(x_mod_ptr_sel == `PTR_SEL_OFF) |=> (xr_ea == $past(xr_raw))) else
		$error("x read corrected while disabled");
	y_off_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(y_mod_ptr_sel == `PTR_SEL_OFF) |=> (y_ea == $past(y_raw))) else
		$error("y corrected while disabled");
	x_circ_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!x_circ_en |-> !xr_circ && !xw_circ) else $error("x circular without enable");
	offset_no_wb_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(xr_valid && xr_mode == mode_offset) |=> !xr_wb_en) else
		$error("offset mode wrote pointer back");
	rev_write_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(xw_valid && !xw_word) |=> !xw_rev_used) else $error("byte write reversed");
	rev_priority_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(xw_valid && xw_rev) |=> (xw_wb_val == $past(rev_next))) else
		$error("circular active with reverse");
	rev_lsb_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(xw_valid && xw_rev) |=> !xw_wb_val[0] && !xw_ea[0]) else
		$error("reversed address lsb set");
	wrap_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(xr_valid && xr_wrap) |=> wrap_seen_reg[0]) else $error("wrap flag lost");
endmodule : circular_and_bit_reversed_agu
`default_nettype wire

// ===== verification/decode_model.sv
/*
 * decode-side model: working register file feeding pointers, taking write-backs
 * assumes write-back arrives one cycle after the request that named the register
 */
`timescale 1ns/100ps
`default_nettype none
module decode_model (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// pointer selects and pointers
	input  wire logic [3:0]  xr_reg,
	input  wire logic [3:0]  xw_reg,
	input  wire logic [3:0]  y_reg,
	output logic      [15:0] xr_ptr,
	output logic      [15:0] xw_ptr,
	output logic      [15:0] y_ptr,
	// write-back
	input  wire logic        xr_wb_en,
	input  wire logic [15:0] xr_wb_val,
	input  wire logic        xw_wb_en,
	input  wire logic [15:0] xw_wb_val,
	input  wire logic        y_wb_en,
	input  wire logic [15:0] y_wb_val,
	// preload
	input  wire logic        ld_en,
	input  wire logic [3:0]  ld_idx,
	input  wire logic [15:0] ld_val
);
	logic [15:0] w_reg [16];
	logic [3:0]  xr_last, xw_last, y_last;

	assign xr_ptr = w_reg[xr_reg];
	assign xw_ptr = w_reg[xw_reg];
	assign y_ptr  = w_reg[y_reg];

	always_ff @(posedge aclk) begin
		xr_last <= xr_reg;
		xw_last <= xw_reg;
		y_last  <= y_reg;
		if (!aresetn) begin
			w_reg <= '{default: 16'h0000};
		end else begin
			if (ld_en) w_reg[ld_idx] <= ld_val;
			if (xr_wb_en) w_reg[xr_last] <= xr_wb_val;
			if (xw_wb_en) w_reg[xw_last] <= xw_wb_val;
			if (y_wb_en) w_reg[y_last] <= y_wb_val;
		end
	end
endmodule : decode_model
`default_nettype wire

// ===== verification/tb_top.sv
/*
 * testbench: register bus, circular correction and bit-reversed writes
 * assumes agu_consts.svh on the include path and decode_model beside the design
 */
`timescale 1ns/100ps
`default_nettype none
`include "agu_consts.svh"
module tb_top
	import agu_pkg::*;
();
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	logic        xr_valid = 1'b0, xw_valid = 1'b0, y_valid = 1'b0, xw_word = 1'b0;
	logic [3:0]  xr_reg = 4'h0, xw_reg = 4'h0, y_reg = 4'h0, ld_idx = 4'h0;
	logic [15:0] xr_offset = 16'h0000, xw_offset = 16'h0000, y_offset = 16'h0000;
	addr_mode_t  xr_mode = mode_indirect, xw_mode = mode_indirect, y_mode = mode_indirect;
	wire logic [15:0] xr_ptr, xw_ptr, y_ptr, xr_ea, xw_ea, y_ea;
	wire logic [15:0] xr_wb_val, xw_wb_val, y_wb_val;
	wire logic   xr_wb_en, xw_wb_en, y_wb_en, xw_rev_used;
	logic        ld_en = 1'b0;
	logic [15:0] ld_val = 16'h0000;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          n_errors = 0, comparisons = 0, cycles = 0;

	circular_and_bit_reversed_agu circular_and_bit_reversed_agu_i (.*);
	decode_model decode_model_i (.*);

	always #10 aclk = ~aclk;

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (n_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
		logic sa, sw, sb;
		sb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!sb) begin
			@(negedge aclk);
			sa = s_axi_awready;
			sw = s_axi_wready;
			sb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (sa) s_axi_awvalid <= 1'b0;
			if (sw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
		logic sa, sr;
		sr = 1'b0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!sr) begin
			@(negedge aclk);
			sa = s_axi_arready;
			sr = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (sa) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(rd, {16'h0000, e});
		chk({30'h0, rs}, {30'h0, er});
	endtask : rchk

	task automatic setw(input logic [3:0] i, input logic [15:0] v);
		@(posedge aclk);
		ld_en  <= 1'b1;
		ld_idx <= i;
		ld_val <= v;
		@(posedge aclk);
		ld_en <= 1'b0;
	endtask : setw

	// one request on unit s (0 x read, 1 x write, 2 y), results settled on return
	task automatic agu(input int s, input logic [3:0] r, input logic [15:0] o,
			input addr_mode_t m, input logic wd);
		@(posedge aclk);
		xr_valid <= (s == 0);
		xw_valid <= (s == 1);
		y_valid  <= (s == 2);
		{xr_reg, xw_reg, y_reg} <= {r, r, r};
		{xr_offset, xw_offset, y_offset} <= {o, o, o};
		xr_mode <= m;
		xw_mode <= m;
		y_mode  <= m;
		xw_word <= wd;
		@(posedge aclk);
		{xr_valid, xw_valid, y_valid} <= 3'b000;
		#1;
	endtask : agu

	task automatic ck(input logic [15:0] ea, input logic en, input logic [15:0] wb,
			input logic [15:0] e_ea, input logic e_en, input logic [15:0] e_wb);
		chk({ea, e_en ? wb : e_wb}, {e_ea, e_wb});
		chk({31'h0, en}, {31'h0, e_en});
	endtask : ck

	function automatic logic [3:0] rev4(input logic [3:0] a);
		return {a[0], a[1], a[2], a[3]};
	endfunction : rev4

	task automatic t_regs();
		logic [15:0] rv [6] = '{`RST_BUF_START, `RST_BUF_END, `RST_BUF_START,
				`RST_BUF_END, `RST_ADDR_MODE_CTRL, `RST_REV_CTRL};
		for (int i = 0; i < 6; i++) rchk(8'(4 * i), rv[i], `RESP_OKAY);
		rchk(8'h1C, 16'h0000, `RESP_SLVERR);
		axi_wr(8'h1C, 16'h1234);
		chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
		axi_wr(`OFF_Y_BUF_END, 16'hA5C3);
		rchk(`OFF_Y_BUF_END, 16'hA5C3, `RESP_OKAY);
	endtask : t_regs

	task automatic t_circ();
		axi_wr(`OFF_X_BUF_START, 16'h1000);
		axi_wr(`OFF_X_BUF_END, 16'h101E);
		axi_wr(`OFF_Y_BUF_START, 16'h2000);
		axi_wr(`OFF_Y_BUF_END, 16'h200E);
		axi_wr(`OFF_ADDR_MODE_CTRL, 16'hCF32);
		setw(4'h2, 16'h101E);
		setw(4'h3, 16'h200E);
		agu(0, 4'h2, 16'h0004, mode_pre, 1'b1);
		ck(xr_ea, xr_wb_en, xr_wb_val, 16'h1002, 1'b1, 16'h1002);
		agu(1, 4'h2, 16'hFFFA, mode_pre, 1'b1);
		ck(xw_ea, xw_wb_en, xw_wb_val, 16'h101C, 1'b1, 16'h101C);
		agu(0, 4'h2, 16'h0008, mode_offset, 1'b1);
		ck(xr_ea, xr_wb_en, xr_wb_val, 16'h1004, 1'b0, 16'h0000);
		agu(0, 4'h5, 16'h0008, mode_offset, 1'b1);
		ck(xr_ea, xr_wb_en, xr_wb_val, 16'h0008, 1'b0, 16'h0000);
		agu(2, 4'h3, 16'h0003, mode_pre, 1'b1);
		ck(y_ea, y_wb_en, y_wb_val, 16'h2000, 1'b1, 16'h2000);
		rchk(`OFF_STATUS, 16'h0007, `RESP_OKAY);
		axi_wr(`OFF_STATUS, 16'h0005);
		rchk(`OFF_STATUS, 16'h0002, `RESP_OKAY);
	endtask : t_circ

	task automatic t_off();
		logic [15:0] cv [2] = '{16'hCFFF, 16'h0F32};
		for (int i = 0; i < 2; i++) begin
			axi_wr(`OFF_ADDR_MODE_CTRL, cv[i]);
			agu(0, 4'h2, 16'h0008, mode_offset, 1'b1);
			chk({16'h0, xr_ea}, 32'h00001024);
			agu(1, 4'h2, 16'h0008, mode_offset, 1'b1);
			chk({16'h0, xw_ea}, 32'h00001024);
			agu(2, 4'h3, 16'h0010, mode_offset, 1'b1);
			chk({16'h0, y_ea}, 32'h00002010);
		end
	endtask : t_off

	task automatic t_rev();
		logic [15:0] ev;
		axi_wr(`OFF_X_BUF_START, 16'h0800);
		axi_wr(`OFF_X_BUF_END, 16'h0806);
		axi_wr(`OFF_ADDR_MODE_CTRL, 16'h82F2);
		axi_wr(`OFF_REV_CTRL, 16'h8008);
		// no read through the reversed pointer straight after the control write
		setw(4'h2, 16'h0800);
		for (int k = 0; k < 16; k++) begin
			agu(1, 4'h2, 16'h0002, mode_post, 1'b1);
			ev = 16'h0800 | {11'h0, rev4(4'(k)), 1'b0};
			chk({15'h0, xw_rev_used, xw_ea}, {15'h0, 1'b1, ev});
		end
		setw(4'h2, 16'h0806);
		agu(0, 4'h2, 16'h0002, mode_pre, 1'b1);
		chk({16'h0, xr_ea}, 32'h00000800);
		agu(1, 4'h2, 16'h0002, mode_pre, 1'b1);
		chk({15'h0, xw_rev_used, xw_ea}, {15'h0, 1'b1, 16'h0810});
		setw(4'h2, 16'h0800);
		agu(1, 4'h2, 16'h0001, mode_pre, 1'b0);
		chk({15'h0, xw_rev_used, xw_ea}, {15'h0, 1'b0, 16'h0801});
		agu(1, 4'h2, 16'h0002, mode_indirect, 1'b1);
		chk({15'h0, xw_rev_used, xw_ea}, {15'h0, 1'b0, 16'h0801});
	endtask : t_rev

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_circ();
		t_off();
		t_rev();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
